// >>> rtl/enhanced_capture_unit_map.vh
// Register offsets, field positions, mode codes and reset values of the capture/compare unit
`ifndef ENHANCED_CAPTURE_UNIT_MAP_VH
`define ENHANCED_CAPTURE_UNIT_MAP_VH
// ======================================
// Register byte addresses (printed index times four)
`define MODE_CTRL_IDX 8'h17
`define MODE_CTRL_ADDR 12'h05C
`define CAPT_LOW_ADDR 12'h100
`define CAPT_HIGH_ADDR 12'h104
`define FLAG_ADDR 12'h108
`define DUTY_HIGH_ADDR 12'h10C
`define COMPARE_ADDR 12'h110
// ======================================
// Field positions
`define MODE_LSB 0
`define MODE_MSB 3
`define DUTY_LSB 4
`define DUTY_MSB 5
`define CFG_LSB 6
`define CFG_MSB 7
`define FLAG_BIT 2
// ======================================
// Mode codes
`define MODE_OFF 4'h0
`define MODE_RSVD_A 4'h1
`define MODE_CMP_TOGGLE 4'h2
`define MODE_RSVD_B 4'h3
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLEAR 4'h9
`define MODE_CMP_SOFT 4'hA
`define MODE_CMP_SPECIAL 4'hB
`define MODE_PWM_HH 4'hC
`define MODE_PWM_LL 4'hD
`define MODE_PWM_LH 4'hE
// Output configurations
`define CFG_SINGLE 2'b00
`define CFG_FWD 2'b01
`define CFG_HALF 2'b10
`define CFG_REV 2'b11
// ======================================
// Reset value and prescaler match counts
`define MODE_CTRL_RST 8'h00
`define PRESCALE_4 4'h3
`define PRESCALE_16 4'hF
`endif

// >>> rtl/enhanced_capture_unit_mode_control_capture.v
// Mode control register, capture engine and output steering of the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
`include "enhanced_capture_unit_map.vh"
// What this block does
// - Mode 0000 switches the unit off and clears prescaler and compare latch; flag and capture pair keep their values.
// - Codes 0001 and 0011 are reserved and select no behaviour.
// - Mode 0010 toggles compare output on Timer1 match and sets the flag.
// - Capture codes 0100..0111 pick falling, rising, fourth and sixteenth rising edge.
// - Set and clear compare modes drive the output high or low and set flag.
// - Software interrupt compare mode only sets the flag; output untouched.
// - Mode 1011 match sets flag, resets Timer1, starts conversion if converter enabled.
// - PWM codes 1100, 1101, 1110 set polarity of the four outputs.
// - Config 00 modulates A only; 10 modulates A and B; others revert to port.
// - Config 01 modulates D, A active; config 11 modulates B, C active.
// - Non-PWM modes: A is capture/compare, B, C, D revert to port pins.
// - Control bits 5..4 are the duty low bits, ignored outside PWM.
// - Each qualifying capture copies the 16-bit Timer1 count into the pair.
// - Each capture sets the flag; only software clears it.
// - A new capture overwrites the pair even if not yet read.
// - A port write changing an output-driven capture pin counts as an event.
// - Prescaler counter clears when unit is off or not capturing.
// - Direct prescaler switches keep the counter and may raise the flag.
// - Capture and compare use Timer1; PWM uses Timer2.
// - Clearing the control register forces the compare output latch low.
module enhanced_capture_unit_mode_control_capture #(
	parameter TIMER_W = 16
)(
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output wire hreadyout,
	output wire hresp,
	input wire capture_pin_in,
	input wire [TIMER_W-1:0] timer_one_count,
	input wire [7:0] timer_two_count,
	input wire pwm_modulation,
	input wire pwm_modulation_deadband_b,
	input wire port_a_out,
	input wire port_b_out,
	input wire port_c_out,
	input wire port_d_out,
	input wire converter_enabled,
	output wire unit_interrupt_flag,
	output reg timer_one_reset,
	output reg conversion_start,
	output wire compare_uses_timer_two,
	output wire [9:0] pwm_duty_value,
	output wire output_a,
	output wire output_b,
	output wire output_c,
	output wire output_d
);
// ======================================
// Bus slave: zero wait states, always OKAY
	reg wr_pend_r;
	reg [11:0] wr_addr_r;
	reg [31:0] rd_word_nxt;
	wire addr_phase;
	reg [7:0] mode_ctrl_r;
	reg [7:0] mode_ctrl_nxt;
	reg [TIMER_W-1:0] capture_pair_r;
	reg [TIMER_W-1:0] compare_val_r;
	reg [7:0] duty_high_r;
	reg flag_r;
	wire [3:0] mode_select_field;
	wire [1:0] output_config_bits;
	wire [1:0] duty_low_bits;
	wire flag_clear;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_phase = hsel & htrans[1] & hready;
	assign mode_select_field = mode_ctrl_r[`MODE_MSB:`MODE_LSB];
	assign output_config_bits = mode_ctrl_r[`CFG_MSB:`CFG_LSB];
	assign duty_low_bits = mode_ctrl_r[`DUTY_MSB:`DUTY_LSB];
	// Address only latched when a write is taken, so idle cycles cannot retarget it
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 12'h000;
		end
		else
		begin
			wr_pend_r <= addr_phase & hwrite;
			if (addr_phase & hwrite)
				wr_addr_r <= haddr[11:0];
		end
	end
	// Read word chosen in the address phase, registered for the data phase
	always @*
	begin
		rd_word_nxt = 32'h0000_0000;
		case (haddr[11:0])
			`MODE_CTRL_ADDR: rd_word_nxt = {24'h00_0000, mode_ctrl_r};
			`CAPT_LOW_ADDR: rd_word_nxt = {24'h00_0000, capture_pair_r[7:0]};
			`CAPT_HIGH_ADDR: rd_word_nxt = {24'h00_0000, capture_pair_r[15:8]};
			`FLAG_ADDR: rd_word_nxt = {29'h0, flag_r, 2'b00};
			`DUTY_HIGH_ADDR: rd_word_nxt = {24'h00_0000, duty_high_r};
			`COMPARE_ADDR: rd_word_nxt = {{(32-TIMER_W){1'b0}}, compare_val_r};
			default: rd_word_nxt = 32'h0000_0000;
		endcase
	end
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (addr_phase & !hwrite)
			hrdata <= rd_word_nxt;
	end
// ======================================
// Write strobes, one per register, valid in the data phase
	wire wr_mode;
	wire wr_capt_low;
	wire wr_capt_high;
	wire wr_flag;
	wire wr_duty_high;
	wire wr_compare;
	assign wr_mode = wr_pend_r && wr_addr_r == `MODE_CTRL_ADDR;
	assign wr_capt_low = wr_pend_r && wr_addr_r == `CAPT_LOW_ADDR;
	assign wr_capt_high = wr_pend_r && wr_addr_r == `CAPT_HIGH_ADDR;
	assign wr_flag = wr_pend_r && wr_addr_r == `FLAG_ADDR;
	assign wr_duty_high = wr_pend_r && wr_addr_r == `DUTY_HIGH_ADDR;
	assign wr_compare = wr_pend_r && wr_addr_r == `COMPARE_ADDR;
	always @*
	begin
		mode_ctrl_nxt = mode_ctrl_r;
		if (wr_mode)
			mode_ctrl_nxt = hwdata[7:0];
	end
	// Writing a one leaves the flag alone, so a set cannot be lost to a stale image
	assign flag_clear = wr_flag && !hwdata[`FLAG_BIT];
// ======================================
// Capture pin synchroniser and edge detect
	reg sync1_r;
	reg sync2_r;
	reg prev_r;
	wire rise;
	wire fall;
	// The pin reflects port writes too when driven as output, so those edges count
	// Stages reset low like the idle pin, so no false edge follows reset
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			prev_r <= 1'b0;
		end
		else
		begin
			sync1_r <= capture_pin_in;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end
	assign rise = sync2_r & ~prev_r;
	assign fall = ~sync2_r & prev_r;
// ======================================
// Mode decode
	wire is_capture;
	wire is_compare;
	wire is_pwm;
	assign is_capture = mode_select_field[3:2] == 2'b01;
	assign is_compare = mode_select_field == `MODE_CMP_TOGGLE | mode_select_field[3:2] == 2'b10;
	assign is_pwm = mode_select_field[3:2] == 2'b11;
	assign compare_uses_timer_two = is_pwm;
	assign pwm_duty_value = is_pwm ? {duty_high_r, duty_low_bits} : 10'h000;
// ======================================
// Prescaler and capture
	reg [3:0] presc_r;
	reg capture_evt;
	wire hit_4;
	wire hit_16;
	assign hit_4 = presc_r[1:0] == `PRESCALE_4;
	assign hit_16 = presc_r == `PRESCALE_16;
	// Mode changes inside capture keep the counter, so a stale count may fire early
	always @*
	begin
		capture_evt = 1'b0;
		case (mode_select_field)
			`MODE_CAP_FALL: capture_evt = fall;
			`MODE_CAP_RISE: capture_evt = rise;
			`MODE_CAP_RISE4: capture_evt = rise && hit_4;
			`MODE_CAP_RISE16: capture_evt = rise && hit_16;
			default: capture_evt = 1'b0;
		endcase
	end
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			presc_r <= 4'h0;
		else if (!is_capture)
			presc_r <= 4'h0;
		else if (rise)
			presc_r <= presc_r + 4'h1;
	end
// ======================================
// Capture register pair
	// Software may preload the pair; a capture in the same cycle wins
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			capture_pair_r <= {TIMER_W{1'b0}};
		else if (capture_evt)
			capture_pair_r <= timer_one_count;
		else if (wr_capt_low)
			capture_pair_r[7:0] <= hwdata[7:0];
		else if (wr_capt_high)
			capture_pair_r[15:8] <= hwdata[7:0];
	end
// ======================================
// Compare
	reg match_d_r;
	reg cmp_out_r;
	wire match;
	wire match_evt;
	assign match = is_compare && timer_one_count == compare_val_r;
	assign match_evt = match & ~match_d_r;
// ======================================
// Configuration registers
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mode_ctrl_r <= `MODE_CTRL_RST;
			compare_val_r <= {TIMER_W{1'b0}};
			duty_high_r <= 8'h00;
		end
		else
		begin
			mode_ctrl_r <= mode_ctrl_nxt;
			if (wr_compare)
				compare_val_r <= hwdata[TIMER_W-1:0];
			if (wr_duty_high)
				duty_high_r <= hwdata[7:0];
		end
	end
// ======================================
// Special event pulses, one cycle per match onset
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			match_d_r <= 1'b0;
			timer_one_reset <= 1'b0;
			conversion_start <= 1'b0;
		end
		else
		begin
			match_d_r <= match;
			timer_one_reset <= match_evt && mode_select_field == `MODE_CMP_SPECIAL;
			conversion_start <= match_evt && mode_select_field == `MODE_CMP_SPECIAL
				&& converter_enabled;
		end
	end
// ======================================
// Compare output latch
	// Held low while off, so the first toggle after enabling always goes high
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cmp_out_r <= 1'b0;
		else if (mode_select_field == `MODE_OFF)
			cmp_out_r <= 1'b0;
		else if (match_evt)
		begin
			case (mode_select_field)
				`MODE_CMP_TOGGLE: cmp_out_r <= ~cmp_out_r;
				`MODE_CMP_SET: cmp_out_r <= 1'b1;
				`MODE_CMP_CLEAR: cmp_out_r <= 1'b0;
				default: cmp_out_r <= cmp_out_r;
			endcase
		end
	end
// ======================================
// Interrupt flag
	// Set wins over a software clear in the same cycle
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flag_r <= 1'b0;
		else if (capture_evt || match_evt)
			flag_r <= 1'b1;
		else if (flag_clear)
			flag_r <= 1'b0;
	end
	assign unit_interrupt_flag = flag_r;
// ======================================
// Output steering
	reg [3:0] act_r;
	reg [3:0] use_r;
	reg [3:0] inv;
	reg [3:0] sel;
	always @*
	begin
		inv = 4'b0000;
		case (mode_select_field)
			`MODE_PWM_LL: inv = 4'b1111;
			`MODE_PWM_LH: inv = 4'b0101;
			default: inv = 4'b0000;
		endcase
		// Bit order is {d, c, b, a}; act is the active-level drive before polarity
		sel = 4'b0000;
		act_r = 4'b0000;
		use_r = 4'b0000;
		if (is_pwm)
		begin
			case (output_config_bits)
				`CFG_SINGLE:
				begin
					use_r = 4'b0001;
					act_r = {3'b000, pwm_modulation};
				end
				`CFG_FWD:
				begin
					use_r = 4'b1111;
					act_r = {pwm_modulation, 3'b001};
				end
				`CFG_HALF:
				begin
					use_r = 4'b0011;
					act_r = {2'b00, pwm_modulation_deadband_b, pwm_modulation};
				end
				default:
				begin
					use_r = 4'b1111;
					act_r = {2'b01, pwm_modulation, 1'b0};
				end
			endcase
			sel = (act_r ^ inv) & use_r;
		end
		else if (mode_select_field != `MODE_OFF)
		begin
			use_r = {3'b000, is_compare};
			sel = {3'b000, cmp_out_r};
		end
	end
// ======================================
// Pin multiplexers
	// Unused outputs fall back to the port latches with no extra delay
	reg [3:0] pin_nxt;
	always @*
	begin
		pin_nxt[0] = use_r[0] ? sel[0] : port_a_out;
		pin_nxt[1] = use_r[1] ? sel[1] : port_b_out;
		pin_nxt[2] = use_r[2] ? sel[2] : port_c_out;
		pin_nxt[3] = use_r[3] ? sel[3] : port_d_out;
	end
	assign output_a = pin_nxt[0];
	assign output_b = pin_nxt[1];
	assign output_c = pin_nxt[2];
	assign output_d = pin_nxt[3];
endmodule // enhanced_capture_unit_mode_control_capture
`default_nettype wire

// >>> bench/enhanced_capture_unit_props.sv
// Port checker for the capture unit
`timescale 1ns/1ps
`default_nettype none
module enhanced_capture_unit_props (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire port_b_out,
	input wire port_c_out,
	input wire port_d_out,
	input wire output_b,
	input wire output_c,
	input wire output_d,
	input wire unit_interrupt_flag,
	input wire compare_uses_timer_two,
	input wire [9:0] pwm_duty_value
);
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
// ==========
// Steps
sequence pwm_off;
	!compare_uses_timer_two;
endsequence
sequence rst_gone;
	$rose(hresetn);
endsequence
sequence flag_drop;
	$fell(unit_interrupt_flag);
endsequence
a_resp_okay: assert property (hresp == 1'b0)
	else $error("hresp not okay");
a_ready_high: assert property (hreadyout == 1'b1)
	else $error("hreadyout low");
a_duty_idle: assert property (pwm_off |-> pwm_duty_value == 10'h0)
	else $error("duty value outside pwm");
a_port_b: assert property (pwm_off |-> output_b == port_b_out)
	else $error("output_b not port");
a_port_c: assert property (pwm_off |-> output_c == port_c_out)
	else $error("output_c not port");
a_port_d: assert property (pwm_off |-> output_d == port_d_out)
	else $error("output_d not port");
a_flag_reset: assert property (rst_gone |-> !unit_interrupt_flag)
	else $error("flag set after reset");
a_flag_sticky: assert property (flag_drop |-> $past(hsel && htrans[1] && hwrite && hready, 2))
	else $error("flag cleared by hardware");
endmodule // enhanced_capture_unit_props
`default_nettype wire

// >>> bench/cap_source.sv
// Signal source on the capture pin
`timescale 1ns/1ps
`default_nettype none
module cap_source (
	input wire hclk,
	output logic pin
);
initial pin = 1'b0;
// Pulses of w cycles high and low; slow pulses test the synchroniser
task automatic edges(input int n, input int w);
	repeat (n)
	begin
		repeat (w) @(posedge hclk);
		pin <= 1'b1;
		repeat (w) @(posedge hclk);
		pin <= 1'b0;
	end
endtask
endmodule // cap_source
`default_nettype wire

// >>> bench/tb.sv
// Testbench of the capture unit
`timescale 1ns/1ps
`default_nettype none
module tb;
logic hclk, hresetn, hsel, hwrite, pwm, rd_ph, cen, pwmb, ia, ib;
logic [15:0] cv;
logic [3:0] e;
wire t1rst, conv, ob, oc, od;
int pulses, p0;
logic [1:0] htrans;
logic [31:0] haddr, hwdata;
logic [15:0] t1, last;
logic [3:0] po;
wire hready, pin, fa, flag, t2;
wire [31:0] hrdata;
wire [9:0] duty;
logic [31:0] q[$];
int error_cnt, n_tests, seed, cyc;
cap_source src (.hclk(hclk), .pin(pin));
enhanced_capture_unit_mode_control_capture uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hready), .hresp(), .capture_pin_in(pin),
	.timer_one_count(t1), .timer_two_count(8'h0), .pwm_modulation(pwm),
	.pwm_modulation_deadband_b(pwmb), .port_a_out(po[0]), .port_b_out(po[1]),
	.port_c_out(po[2]), .port_d_out(po[3]), .converter_enabled(cen),
	.unit_interrupt_flag(flag), .timer_one_reset(t1rst), .conversion_start(conv),
	.compare_uses_timer_two(t2), .pwm_duty_value(duty), .output_a(fa), .output_b(ob),
	.output_c(oc), .output_d(od));
always @(posedge hclk)
	pulses <= pulses + t1rst + conv;
// ==========
// Clock, timeout, verdict
initial
begin
	hclk = 1'b0;
	forever #2.5 hclk = ~hclk;
end
task end_of_test;
	$display("Checks %0d errors %0d", n_tests, error_cnt);
	if (error_cnt == 0 && n_tests > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
endtask
always @(posedge hclk)
begin
	cyc++;
	if (cyc == 4000)
	begin
		error_cnt++;
		end_of_test;
	end
end
task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
	n_tests++;
	if (s !== e)
	begin
		error_cnt++;
		$display("Error %s expected %h seen %h", nm, e, s);
	end
endtask
// Read results are matched to the oldest note
always @(posedge hclk)
	if (rd_ph && hready)
	begin
		rd_ph <= 1'b0;
		chk("hrdata", q.pop_front(), hrdata);
	end
// ==========
// Bus and stimulus
task bus(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
	hsel <= 1'b1;
	htrans <= 2'b10;
	haddr <= {20'h0, a};
	hwrite <= w;
	do @(posedge hclk); while (hready !== 1'b1);
	hsel <= 1'b0;
	htrans <= 2'b00;
	hwdata <= d;
	if (!w)
	begin
		q.push_back(e);
		rd_ph <= 1'b1;
	end
	do @(posedge hclk); while (hready !== 1'b1);
endtask
// Off first, so the prescaler restarts and no stray flag is left
task mode(input logic [7:0] m);
	bus(1'b1, 12'h5C, 32'h0, 32'h0);
	bus(1'b1, 12'h5C, {24'h0, m}, 32'h0);
	bus(1'b1, 12'h108, 32'h0, 32'h0);
endtask
// Timer held still across the event, as a synchronous count would be
task cap(input int n, input logic [31:0] f);
	t1 <= $random(seed);
	po <= $random(seed);
	src.edges(n, 3 + n % 3);
	repeat (6) @(posedge hclk);
	if (f[2])
		last = t1;
	bus(1'b0, 12'h100, 32'h0, {24'h0, last[7:0]});
	bus(1'b0, 12'h104, 32'h0, {24'h0, last[15:8]});
	bus(1'b0, 12'h108, 32'h0, f);
endtask
// Compare value never zero, so the idle timer value cannot match early
task cmp(input logic [7:0] m, input logic e_a, input int e_p);
	cv = $random(seed);
	cv[0] = 1'b1;
	t1 <= 16'h0000;
	p0 = pulses;
	bus(1'b1, 12'h110, {16'h0, cv}, 32'h0);
	mode(m);
	t1 <= cv;
	repeat (3) @(posedge hclk);
	chk("output_a", {31'h0, e_a}, {31'h0, fa});
	chk("pulses", e_p, pulses - p0);
	bus(1'b0, 12'h108, 32'h0, 32'h4);
endtask
initial
begin
	{hsel, hwrite, pwm, rd_ph, hresetn, cen, pwmb} = 7'h0;
	{htrans, haddr, hwdata, t1, last, po} = 0;
	seed = 32;
	repeat (6) @(posedge hclk);
	hresetn <= 1'b1;
	@(posedge hclk);
	bus(1'b0, 12'h5C, 32'h0, 32'h0);
	bus(1'b0, 12'h200, 32'h0, 32'h0);
	bus(1'b1, 12'h5C, 32'h35, 32'h0);
	bus(1'b0, 12'h5C, 32'h0, 32'h35);
	repeat (2) cap(1, 32'h4);
	mode(8'h1);
	cap(1, 32'h0);
	mode(8'h3);
	cap(1, 32'h0);
	mode(8'h4);
	cap(1, 32'h4);
	mode(8'h6);
	cap(2, 32'h0);
	mode(8'h6);
	cap(3, 32'h0);
	cap(1, 32'h4);
	mode(8'h7);
	cap(15, 32'h0);
	cap(1, 32'h4);
	cmp(8'h02, 1'b1, 0);
	cmp(8'h08, 1'b1, 0);
	t1 <= 16'h0000;
	bus(1'b1, 12'h5C, 32'h9, 32'h0);
	t1 <= cv;
	repeat (3) @(posedge hclk);
	chk("output_a", 32'h0, {31'h0, fa});
	cmp(8'h0A, 1'b0, 0);
	cen <= 1'b1;
	cmp(8'h0B, 1'b0, 2);
	for (int k = 0; k < 12; k++)
	begin
		mode({k[1:0], 2'b11, 2'b11, k[3:2]});
		ia = k[3:2] != 2'b00;
		ib = k[3:2] == 2'b01;
		repeat (4)
		begin
			@(posedge hclk);
			pwm <= $random(seed);
			pwmb <= $random(seed);
			#1;
			case (k[1:0])
				2'd0: e = {po[3], po[2], po[1], pwm ^ ia};
				2'd1: e = {pwm ^ ib, ia, ib, ~ia};
				2'd2: e = {po[3], po[2], pwmb ^ ib, pwm ^ ia};
				default: e = {ib, ~ia, pwm ^ ib, ia};
			endcase
			chk("outputs", {28'h0, e}, {28'h0, od, oc, ob, fa});
			chk("timer2", 32'h1, {31'h0, t2});
			chk("duty", 32'h3, {22'h0, duty});
		end
	end
	end_of_test;
end
endmodule // tb
bind enhanced_capture_unit_mode_control_capture enhanced_capture_unit_props chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
	.hready, .hreadyout, .hresp, .port_b_out, .port_c_out, .port_d_out, .output_b,
	.output_c, .output_d, .unit_interrupt_flag, .compare_uses_timer_two, .pwm_duty_value);
`default_nettype wire
